// ### actuator_driver_spi_control.sv
// serial control interface, register logic and driver gating of the actuator driver
`timescale 1ns/100ps
module actuator_driver_spi_control #(
    parameter int RECOV_PERIOD = actuator_pkg::RECOV_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_clk,
    input wire logic chip_select_n,
    input wire logic serial_in_pin,
    output logic serial_out,
    output logic serial_out_oe,
    input wire actuator_pkg::fault_pins_t fault_pins,
    input wire actuator_pkg::config_pins_t config_pins,
    output logic [17:1] driver_on,
    output logic [3:0] current_image_output,
    output logic standby_mode
);
    // ====================================================================
    // link side, rising edges: shift in, count, load outgoing word
    // ====================================================================
    logic armed;
    logic [23:0] rx_shift;
    logic [actuator_pkg::CNT_W-1:0] bit_count;
    logic frame_seq;
    logic [23:0] tx_word;
    logic started;
    logic out_bit;
    logic [23:0] commit_word;
    logic commit_toggle;
    logic seen_seq;
    actuator_pkg::state_t s_reg;
    actuator_pkg::state_t s_next;

    always_ff @(posedge spi_clk or posedge chip_select_n or posedge rst) begin
        if (rst || chip_select_n) begin
            armed <= 1'b1;
        end else begin
            armed <= 1'b0;
        end
    end

    // snap stays frozen while the frame runs, so reading it here is a quasi-static crossing
    always_ff @(posedge spi_clk or posedge rst) begin
        if (rst) begin
            rx_shift <= 24'h000000;
            bit_count <= '0;
            frame_seq <= 1'b0;
            tx_word <= actuator_pkg::STATUS_RESET;
        end else begin
            rx_shift <= {serial_in_pin, rx_shift[23:1]};
            if (armed) begin
                bit_count <= 5'h01;
                frame_seq <= ~frame_seq;
                if (serial_in_pin) begin
                    tx_word <= {1'b1, 22'h000000, s_reg.snap[actuator_pkg::ST_NO_ERROR]};
                end else begin
                    tx_word <= s_reg.snap;
                end
            end else if (bit_count != actuator_pkg::CNT_OVER) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // ====================================================================
    // link side, falling edges: output bit
    // ====================================================================
    always_ff @(negedge spi_clk or posedge chip_select_n or posedge rst) begin
        if (rst || chip_select_n) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    always_ff @(negedge spi_clk or posedge rst) begin
        if (rst) begin
            out_bit <= 1'b0;
        end else begin
            if (bit_count < actuator_pkg::CNT_FULL) begin
                out_bit <= tx_word[bit_count];
            end else begin
                out_bit <= 1'b0;
            end
        end
    end

    // no-error bit until first falling edge, driven only while selected
    assign serial_out = started ? out_bit : s_reg.snap[actuator_pkg::ST_NO_ERROR];
    assign serial_out_oe = ~chip_select_n;

    // ====================================================================
    // frame end: capture on chip select rise
    // ====================================================================
    always_ff @(posedge chip_select_n or posedge rst) begin
        if (rst) begin
            commit_word <= 24'h000000;
            commit_toggle <= 1'b0;
            seen_seq <= 1'b0;
        end else begin
            seen_seq <= frame_seq;
            if (bit_count == actuator_pkg::CNT_FULL && frame_seq != seen_seq) begin
                commit_word <= rx_shift;
                commit_toggle <= ~commit_toggle;
            end
        end
    end

    // ====================================================================
    // system clock side
    // ====================================================================
    function automatic logic [3:0] cm_decode(input logic [1:0] sel);
        logic [3:0] oh;
        oh = 4'h0;
        unique case (sel)
            2'b00: oh[actuator_pkg::CM_EIGHT] = 1'b1;
            2'b10: oh[actuator_pkg::CM_ONE] = 1'b1;
            2'b01: oh[actuator_pkg::CM_FIVE] = 1'b1;
            2'b11: oh[actuator_pkg::CM_FOUR] = 1'b1;
        endcase
        return oh;
    endfunction

    logic frame_end;
    logic commit;
    logic clear_all;
    logic go_standby;
    logic wake;
    logic supply_off;
    logic global_off;
    logic on_window;
    logic [actuator_pkg::RECOV_W-1:0] on_count;
    logic [23:0] events;
    logic [23:0] clear_mask;
    logic [17:1] want;
    logic [17:1] pwm_ok;
    logic [17:1] oc_ok;

    localparam logic [actuator_pkg::RECOV_W-1:0] LOW_ON =
        actuator_pkg::RECOV_W'(RECOV_PERIOD * actuator_pkg::DUTY_LOW_PCT / 100);
    localparam logic [actuator_pkg::RECOV_W-1:0] HIGH_ON =
        actuator_pkg::RECOV_W'(RECOV_PERIOD * actuator_pkg::DUTY_HIGH_PCT / 100);
    localparam logic [actuator_pkg::RECOV_W-1:0] RECOV_LAST = actuator_pkg::RECOV_W'(RECOV_PERIOD - 1);
    localparam logic [actuator_pkg::SETTLE_W-1:0] SETTLE_LOAD =
        actuator_pkg::SETTLE_W'(actuator_pkg::SETTLE_CYCLES - 1);

    always_comb begin
        s_next = s_reg;
        s_next.cs_s1 = chip_select_n;
        s_next.cs_s2 = s_reg.cs_s1;
        s_next.tog_s1 = commit_toggle;
        s_next.tog_s2 = s_reg.tog_s1;
        s_next.tog_prev = s_reg.tog_s2;
        s_next.flt_s1 = fault_pins;
        s_next.flt_s2 = s_reg.flt_s1;
        s_next.cfg_s1 = config_pins;
        s_next.cfg_s2 = s_reg.cfg_s1;

        frame_end = s_reg.tog_s2 != s_reg.tog_prev;
        commit = frame_end && !commit_word[actuator_pkg::BIT_SELECT];
        clear_all = commit && commit_word[actuator_pkg::BIT_RESET];
        go_standby = commit && !commit_word[actuator_pkg::BIT_ENABLE];
        wake = commit && commit_word[actuator_pkg::BIT_ENABLE] && s_reg.standby;

        if (go_standby) begin
            s_next.ctrl = 24'h000000;
            s_next.standby = 1'b1;
        end else if (commit) begin
            s_next.ctrl = commit_word;
            s_next.standby = 1'b0;
        end

        events = 24'h000000;
        events[17:1] = s_reg.flt_s2.overload;
        events = events & actuator_pkg::CHAN_MASK;
        events[actuator_pkg::ST_WARN] = s_reg.flt_s2.heat_warning_flag;
        events[actuator_pkg::ST_THERMAL] = s_reg.flt_s2.thermal_trip_flag;
        events[actuator_pkg::ST_UNDER] = s_reg.flt_s2.under_voltage;
        events[actuator_pkg::ST_OVER] = s_reg.flt_s2.over_voltage;
        if (s_reg.standby) begin
            events = 24'h000000;
        end

        // clear at frame end, a new event wins
        clear_mask = (clear_all || go_standby) ? actuator_pkg::CLEARABLE : 24'h000000;
        s_next.status = (s_reg.status & ~clear_mask) | events;

        s_next.settle_cnt = (s_reg.settle_cnt != '0) ? s_reg.settle_cnt - 1'b1 : s_reg.settle_cnt;
        if (wake) begin
            s_next.settle_cnt = SETTLE_LOAD;
            s_next.status[actuator_pkg::ST_NOT_READY] = 1'b1;
        end else if (go_standby || s_reg.settle_cnt == '0) begin
            s_next.status[actuator_pkg::ST_NOT_READY] = 1'b0;
        end

        s_next.status[actuator_pkg::ST_NO_ERROR] = ~|s_next.status[22:1];
        s_next.status[actuator_pkg::ST_ALWAYS] = 1'b1;

        // status image for the link only moves while chip select is high
        if (s_reg.cs_s2) begin
            s_next.snap = s_reg.status;
        end

        s_next.recov_cnt = (s_reg.recov_cnt >= RECOV_LAST) ? '0 : s_reg.recov_cnt + 1'b1;
        on_count = s_reg.ctrl[actuator_pkg::BIT_DUTY] ? HIGH_ON : LOW_ON;
        on_window = s_reg.recov_cnt < on_count;

        if (s_reg.ctrl[actuator_pkg::BIT_SUPPLY_RDIS]) begin
            supply_off = s_reg.status[actuator_pkg::ST_UNDER] || s_reg.status[actuator_pkg::ST_OVER];
        end else begin
            supply_off = s_reg.flt_s2.under_voltage || s_reg.flt_s2.over_voltage;
        end
        global_off = s_reg.standby || s_reg.status[actuator_pkg::ST_NOT_READY]
            || s_reg.status[actuator_pkg::ST_THERMAL] || supply_off;

        want = s_reg.ctrl[17:1] & actuator_pkg::CHAN_MASK[17:1];
        pwm_ok = {17{s_reg.cfg_s2.modulation_input_one}};
        pwm_ok[actuator_pkg::PWM_TWO_CHAN] = s_reg.cfg_s2.modulation_input_two;
        pwm_ok = pwm_ok | ~s_reg.cfg_s2.pwm_enable;
        // over-current stops driver, recovery pulses it
        oc_ok = ~s_reg.status[17:1] | (s_reg.cfg_s2.recovery_enable & {17{on_window}});
        s_next.drive = global_off ? 17'h00000 : (want & pwm_ok & oc_ok);
        for (int p = 0; p < actuator_pkg::BRIDGE_PAIRS; p++) begin
            if (want[2 * p + 1] && want[2 * p + 2]) begin
                s_next.drive[2 * p + 1] = 1'b0;
                s_next.drive[2 * p + 2] = 1'b0;
            end
        end

        s_next.cm_onehot = cm_decode(s_reg.ctrl[actuator_pkg::BIT_CM_HI:actuator_pkg::BIT_CM_LO]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.cs_s1 <= 1'b1;
            s_reg.cs_s2 <= 1'b1;
            s_reg.status <= actuator_pkg::STATUS_RESET;
            s_reg.snap <= actuator_pkg::STATUS_RESET;
            s_reg.standby <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign driver_on = s_reg.drive;
    assign current_image_output = s_reg.cm_onehot;
    assign standby_mode = s_reg.standby;

    // ====================================================================
    // checks
    // ====================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence standby_frame_s;
        commit && !commit_word[actuator_pkg::BIT_ENABLE];
    endsequence

    sequence wake_frame_s;
        wake;
    endsequence

    standby_clears_a: assert property (standby_frame_s |=> standby_mode && s_reg.ctrl == 24'h000000)
        else $error("standby frame did not clear control");
    no_error_bit_a: assert property (s_reg.status[0] == ~|s_reg.status[22:1])
        else $error("no-error bit disagrees with status");
    always_one_a: assert property (s_reg.status[23])
        else $error("status top bit not one");
    thermal_off_a: assert property (s_reg.status[actuator_pkg::ST_THERMAL] |=> driver_on == 17'h00000)
        else $error("driver on during thermal shutdown");
    monitor_select_a: assert property (s_reg.ctrl[19:18] == 2'b10 |=> current_image_output[actuator_pkg::CM_ONE])
        else $error("monitor select wrong");
    bridge_lockout_a: assert property (!(driver_on[1] && driver_on[2]) && !(driver_on[9] && driver_on[10]))
        else $error("both drivers of a half bridge on");
    settle_hold_a: assert property (wake_frame_s |=> s_reg.status[18] ##1 driver_on == 17'h00000 [*2])
        else $error("outputs not held during settling");
    overcurrent_off_a: assert property (
        1'b1 |=> (driver_on & $past(s_reg.status[17:1]) & ~$past(s_reg.cfg_s2.recovery_enable)) == 17'h00000)
        else $error("over-current driver left on");
    reset_clear_a: assert property (clear_all && events == 24'h000000 |=>
        (s_reg.status & actuator_pkg::CLEARABLE & ~24'h040000) == 24'h000000)
        else $error("reset bit did not clear status");
    first_load_a: assert property (@(posedge spi_clk) disable iff (rst)
        armed && !serial_in_pin |=> tx_word == s_reg.snap)
        else $error("status word not loaded on first edge");
endmodule // actuator_driver_spi_control

// ### actuator_pkg.sv
// constants, field positions and carrier types of the actuator driver serial control
package actuator_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
    localparam logic [CNT_W-1:0] CNT_OVER = 5'h19;
    // control word fields
    localparam int BIT_SELECT = 0;
    localparam int BIT_CM_LO = 18;
    localparam int BIT_CM_HI = 19;
    localparam int BIT_SUPPLY_RDIS = 20;
    localparam int BIT_DUTY = 21;
    localparam int BIT_RESET = 22;
    localparam int BIT_ENABLE = 23;
    // status word fields
    localparam int ST_NO_ERROR = 0;
    localparam int ST_NOT_READY = 18;
    localparam int ST_WARN = 19;
    localparam int ST_THERMAL = 20;
    localparam int ST_UNDER = 21;
    localparam int ST_OVER = 22;
    localparam int ST_ALWAYS = 23;
    localparam int CHAN_LO = 1;
    localparam int CHAN_HI = 17;
    localparam int PWM_TWO_CHAN = 15;
    localparam int BRIDGE_PAIRS = 5;
    localparam logic [23:0] CHAN_MASK = 24'h02C7FE;
    localparam logic [23:0] CLEARABLE = 24'h7BFFFE;
    localparam logic [23:0] STATUS_RESET = 24'h800001;
    // current monitor one-hot positions
    localparam int CM_ONE = 0;
    localparam int CM_FOUR = 1;
    localparam int CM_FIVE = 2;
    localparam int CM_EIGHT = 3;
    // timing
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int RECOV_FREQ_HZ = 3000;
    localparam int RECOV_PERIOD_CYCLES = CLK_FREQ_HZ / RECOV_FREQ_HZ;
    localparam int DUTY_LOW_PCT = 12;
    localparam int DUTY_HIGH_PCT = 25;
    localparam int SETTLE_US = 50;
    localparam int SETTLE_CYCLES = SETTLE_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int SETTLE_W = 12;
    localparam int RECOV_W = 15;

    typedef struct packed {
        logic [17:1] overload;
        logic over_voltage;
        logic under_voltage;
        logic thermal_trip_flag;
        logic heat_warning_flag;
    } fault_pins_t;

    typedef struct packed {
        logic [17:1] pwm_enable;
        logic [17:1] recovery_enable;
        logic modulation_input_one;
        logic modulation_input_two;
    } config_pins_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic tog_s1;
        logic tog_s2;
        logic tog_prev;
        fault_pins_t flt_s1;
        fault_pins_t flt_s2;
        config_pins_t cfg_s1;
        config_pins_t cfg_s2;
        logic [23:0] ctrl;
        logic [23:0] status;
        logic [23:0] snap;
        logic standby;
        logic [SETTLE_W-1:0] settle_cnt;
        logic [RECOV_W-1:0] recov_cnt;
        logic [17:1] drive;
        logic [3:0] cm_onehot;
    } state_t;
endpackage

// ### spi_master_model.sv
// serial master model that runs frames into the actuator driver
`timescale 1ns/100ps
module spi_master_model (
    output logic spi_clk,
    output logic chip_select_n,
    output logic serial_in_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    localparam time HALF = 24ns;
    initial begin
        spi_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in_pin = 1'b0;
    end
    // ==========================================
    // frame transfer
    // idle-low clock, data set while low, LSB first, nbits clocks
    task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        // chip select must settle into the system clock domain first
        #100ns;
        for (int i = 0; i < nbits; i++) begin
            serial_in_pin = (i < 24) ? tx[i] : 1'b0;
            #HALF;
            spi_clk = 1'b1;
            // a line left undriven is read as unknown
            if (i < 24) rx[i] = serial_out_oe ? serial_out : 1'bx;
            #HALF;
            spi_clk = 1'b0;
        end
        #HALF;
        chip_select_n = 1'b1;
        // released data line: no pull, so show the inverse of the last bit
        serial_in_pin = ~serial_in_pin;
        #100ns;
    endtask
endmodule // spi_master_model

// ### tb.sv
// self-checking bench of the actuator driver serial control
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb;
    localparam int RP = 100;
    localparam logic [23:0] CTRL = 24'h80400E;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic spi_clk, chip_select_n, serial_in_pin, serial_out, serial_out_oe, standby_mode;
    actuator_pkg::fault_pins_t fault_pins = '0;
    actuator_pkg::config_pins_t config_pins = '0;
    logic [17:1] driver_on;
    logic [3:0] current_image_output;
    logic [23:0] rx;
    logic [3:0] cm_exp [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
    int error_cnt = 0;
    int checked = 0;
    always #10ns clk = ~clk;
    actuator_driver_spi_control #(.RECOV_PERIOD(RP)) i_actuator_driver_spi_control (
        .clk(clk), .rst(rst), .spi_clk(spi_clk), .chip_select_n(chip_select_n),
        .serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .fault_pins(fault_pins), .config_pins(config_pins), .driver_on(driver_on),
        .current_image_output(current_image_output), .standby_mode(standby_mode));
    spi_master_model i_spi_master_model (
        .spi_clk(spi_clk), .chip_select_n(chip_select_n), .serial_in_pin(serial_in_pin),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    // ==========================================
    // helpers
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1ns;
    endtask
    task automatic xfer(input logic [23:0] tx, input int nbits = 24);
        wait_clk(1);
        i_spi_master_model.frame(tx, nbits, rx);
        wait_clk(10);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic test_reset();
        `CHK("standby", 1'b1, standby_mode)
        `CHK("drivers", 17'h0, driver_on)
        `CHK("idle oe", 1'b0, serial_out_oe)
        `CHK("monitor", 4'h8, current_image_output)
        xfer(24'h0);
        `CHK("status", 24'h800001, rx)
        $display("reset test done");
    endtask
    task automatic test_activate();
        xfer(CTRL);
        `CHK("standby", 1'b0, standby_mode)
        `CHK("drivers", 17'h0, driver_on)
        xfer(CTRL);
        `CHK("status", 24'h840000, rx)
        wait_clk(2600);
        `CHK("drivers", 17'h02004, driver_on)
        $display("activate test done");
    endtask
    task automatic test_monitor();
        for (int k = 0; k < 4; k++) begin
            xfer(CTRL | (24'(k) << 18));
            `CHK("monitor", cm_exp[k], current_image_output)
        end
        $display("monitor test done");
    endtask
    task automatic test_length();
        xfer(24'h0, 23);
        `CHK("standby", 1'b0, standby_mode)
        xfer(24'h0, 25);
        `CHK("standby", 1'b0, standby_mode)
        `CHK("drivers", 17'h02004, driver_on)
        $display("length test done");
    endtask
    task automatic test_faults();
        fault_pins.heat_warning_flag = 1'b1;
        // let the flag latch before chip select freezes the status image
        wait_clk(10);
        xfer(CTRL);
        `CHK("status", 24'h880000, rx)
        `CHK("drivers", 17'h02004, driver_on)
        // select bit one: second pair answers, control word zero untouched
        xfer(24'h000001);
        `CHK("pair one", 24'h800000, rx)
        `CHK("standby", 1'b0, standby_mode)
        `CHK("drivers", 17'h02004, driver_on)
        fault_pins.heat_warning_flag = 1'b0;
        fault_pins.thermal_trip_flag = 1'b1;
        wait_clk(10);
        `CHK("drivers", 17'h0, driver_on)
        fault_pins.thermal_trip_flag = 1'b0;
        xfer(CTRL);
        `CHK("status", 24'h980000, rx)
        `CHK("drivers", 17'h0, driver_on)
        xfer(CTRL | 24'h400000);
        `CHK("drivers", 17'h02004, driver_on)
        fault_pins.overload[3] = 1'b1;
        wait_clk(10);
        fault_pins.overload[3] = 1'b0;
        xfer(CTRL);
        `CHK("status", 24'h800008, rx)
        `CHK("drivers", 17'h02000, driver_on)
        xfer(CTRL | 24'h400000);
        `CHK("drivers", 17'h02004, driver_on)
        xfer(CTRL | 24'h100000);
        fault_pins.over_voltage = 1'b1;
        wait_clk(10);
        `CHK("drivers", 17'h0, driver_on)
        fault_pins.over_voltage = 1'b0;
        xfer(CTRL | 24'h100000);
        `CHK("status", 24'hC00000, rx)
        `CHK("drivers", 17'h0, driver_on)
        xfer(CTRL | 24'h500000);
        `CHK("drivers", 17'h02004, driver_on)
        $display("fault test done");
    endtask
    task automatic test_recovery();
        int ons;
        config_pins.recovery_enable[3] = 1'b1;
        fault_pins.overload[3] = 1'b1;
        for (int d = 0; d < 2; d++) begin
            xfer(CTRL | (24'(d) << 21));
            wait_clk(200);
            ons = 0;
            // a whole number of periods makes the count independent of phase
            for (int c = 0; c < 4 * RP; c++) begin
                wait_clk(1);
                ons += int'(driver_on[3] === 1'b1);
            end
            `CHK("duty count", (d == 1) ? 100 : 48, ons)
        end
        fault_pins.overload[3] = 1'b0;
        config_pins.recovery_enable[3] = 1'b0;
        xfer(CTRL | 24'h400000);
        $display("recovery test done");
    endtask
    task automatic test_pwm();
        config_pins.pwm_enable[14] = 1'b1;
        wait_clk(10);
        `CHK("drivers", 17'h00004, driver_on)
        config_pins.modulation_input_one = 1'b1;
        wait_clk(10);
        `CHK("drivers", 17'h02004, driver_on)
        xfer(24'h0);
        `CHK("standby", 1'b1, standby_mode)
        `CHK("drivers", 17'h0, driver_on)
        $display("pwm and standby test done");
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        wait_clk(2);
        rst = 1'b0;
        wait_clk(4);
        test_reset();
        test_activate();
        test_monitor();
        test_length();
        test_faults();
        test_recovery();
        test_pwm();
        summarize();
    end
    initial begin
        #2ms;
        error_cnt++;
        summarize();
    end
endmodule // tb
